// ---- verilog/ncp_regs.svh ----
// Purpose: register offsets, field positions and reset values for the
//          clock generation configuration block
// Assumes: byte-wide registers at their printed addresses
// Notes:   definitions only
`ifndef NCP_REGS_SVH
`define NCP_REGS_SVH

// ============================================================
// register offsets
`define NCP_ADDR_FRONT_END 7'h00
`define NCP_ADDR_PS_SEQ 7'h08
`define NCP_ADDR_PS_RATE_DIV 7'h09
`define NCP_ADDR_PLL_TUNE 7'h0a
`define NCP_ADDR_PLL_DIV 7'h0b
`define NCP_ADDR_PLL_SEQ 7'h0c
`define NCP_ADDR_PLL_RATE 7'h0d
`define NCP_ADDR_PLL_POWER 7'h0e

// ============================================================
// reset values
`define NCP_RST_PS_SEQ 8'h00
`define NCP_RST_PS_RATE_DIV 8'h0a
`define NCP_RST_PLL_TUNE 8'h22
`define NCP_RST_PLL_DIV 8'h12
`define NCP_RST_PLL_SEQ 8'h00
`define NCP_RST_PLL_RATE 8'hc0
`define NCP_RST_PLL_POWER 8'h00

// ============================================================
// field positions
`define NCP_FE_ENABLE_BIT 7
`define NCP_PS_RATE_MSB 7
`define NCP_PS_RATE_LSB 5
`define NCP_PS_DIV_MSB 4
`define NCP_PS_DIV_LSB 0
`define NCP_CHP_MSB 7
`define NCP_CHP_LSB 4
`define NCP_FILTER_BIT 3
`define NCP_VCO_MSB 2
`define NCP_VCO_LSB 0
`define NCP_PLL_DIV_MSB 6
`define NCP_PLL_DIV_LSB 0
`define NCP_XTAL_MSB 7
`define NCP_XTAL_LSB 6
`define NCP_PLL_RATE_MSB 2
`define NCP_PLL_RATE_LSB 0
`define NCP_FORCE_VCO_BIT 7
`define NCP_PWDN_BIT 6

`endif

// ---- verilog/ncp_pkg.sv ----
// Purpose: shared types of the clock generation configuration block
// Assumes: nothing
// Notes:   constants live in ncp_regs.svh
`default_nettype none
package ncp_pkg;

  // ============================================================
  // pll power state, one-hot
  typedef enum logic [1:0] {
    NCP_PLL_OFF = 2'b01,
    NCP_PLL_ON = 2'b10
  } ncp_pll_state_t;

endpackage : ncp_pkg

`default_nettype wire

// ---- verilog/ncp_nco_div.sv ----
// Purpose: fractional nco divider, stretches selected periods by one
// Assumes: tickIn is a one-cycle enable at the input rate
// Notes:   a divisor of zero behaves as one, but its periods are never stretched
`timescale 1ns/1ps
`default_nettype none

module ncp_nco_div #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tickIn,
  input wire logic [W-1:0] divisor,
  input wire logic [7:0] seq,
  input wire logic [2:0] rate,
  output logic tickOut
);

  logic [W:0] cnt_r;
  logic [2:0] idx_r;
  logic stretch;
  logic [W:0] target;
  logic wrap;

  // ============================================================
  // period selection
  // a zero rate leaves the pattern out and divides plainly
  assign stretch = (rate != 3'h0) && seq[idx_r];
  assign target = {1'b0, divisor} + {{W{1'b0}}, stretch};
  // cnt counts completed input ticks; short or zero targets wrap at once
  assign wrap = (cnt_r + {{W{1'b0}}, 1'b1}) >= target;

  // ============================================================
  // counter and pattern index
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= '0;
      idx_r <= 3'h0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= tickIn && wrap;
      if (tickIn) begin
        if (wrap) begin
          cnt_r <= '0;
          idx_r <= (idx_r >= rate) ? 3'h0 : idx_r + 3'h1;
        end else begin
          cnt_r <= cnt_r + {{W{1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule : ncp_nco_div

`default_nettype wire

// ---- verilog/ncp_clock_config.sv ----
// Purpose: clock generation configuration: prescaler nco, pll nco,
//          pll tuning outputs and pll power gating
// Assumes: clk is the crystal clock; vcoTick marks one vco cycle
// Notes:   register port is a plain byte write/read port
`timescale 1ns/1ps
`default_nettype none
`include "ncp_regs.svh"

// Summary of operation
// - prescaler output, not crystal, is pll reference
// - prescaler sequence at 08h, resets 00h
// - zero prescaler rate ignores sequence pattern
// - 09h: rate 7:5, divisor 4:0, reset 0Ah
// - rate sets when sequence pattern restarts
// - 0Ah: pump 7:4, filter 3, vco 2:0
// - vco code ascends lowest to highest range
// - pll on only when enabled and not powered down
// - zero pll rate ignores pll divisor register
// - front end enable resets to zero
module ncp_clock_config (
  input wire logic clk,
  input wire logic nrst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic vcoTick,
  output logic [7:0] regRdData,
  output logic pllRefTick,
  output logic pllFbTick,
  output logic pllPowerOn,
  output logic [3:0] chargePumpCurrent,
  output logic loopFilterSelect,
  output logic [2:0] vcoRange,
  output logic [1:0] xtalBias,
  output logic forceVco
);

  // ============================================================
  // register storage
  logic frontEndEnable_r;
  logic [7:0] psSeq_r;
  logic [7:0] psRateDiv_r;
  logic [7:0] pllTune_r;
  logic [7:0] pllDiv_r;
  logic [7:0] pllSeq_r;
  logic [7:0] pllRate_r;
  logic forceVco_r;
  logic pllPowerDown_r;
  // pll divider settings in use, loaded when 0Dh is written
  logic [6:0] pllDivAct_r;
  logic [7:0] pllSeqAct_r;
  logic [2:0] pllRateAct_r;
  ncp_pkg::ncp_pll_state_t pllState_r;
  ncp_pkg::ncp_pll_state_t pllState_nxt;

  // ============================================================
  // address decode
  logic wrFrontEnd;
  logic wrPsSeq;
  logic wrPsRateDiv;
  logic wrPllTune;
  logic wrPllDiv;
  logic wrPllSeq;
  logic wrPllRate;
  logic wrPllPower;
  assign wrFrontEnd = regWrEn && (regAddr == `NCP_ADDR_FRONT_END);
  assign wrPsSeq = regWrEn && (regAddr == `NCP_ADDR_PS_SEQ);
  assign wrPsRateDiv = regWrEn && (regAddr == `NCP_ADDR_PS_RATE_DIV);
  assign wrPllTune = regWrEn && (regAddr == `NCP_ADDR_PLL_TUNE);
  assign wrPllDiv = regWrEn && (regAddr == `NCP_ADDR_PLL_DIV);
  assign wrPllSeq = regWrEn && (regAddr == `NCP_ADDR_PLL_SEQ);
  assign wrPllRate = regWrEn && (regAddr == `NCP_ADDR_PLL_RATE);
  assign wrPllPower = regWrEn && (regAddr == `NCP_ADDR_PLL_POWER);

  // ============================================================
  // read mux
  // reserved and unused bits read as zero; unmapped addresses read 00h
  logic [7:0] rdSel;
  logic [7:0] rdFrontEnd;
  logic [7:0] rdPllRate;
  logic [7:0] rdPllPower;
  assign rdFrontEnd = {frontEndEnable_r, 7'h00};
  assign rdPllRate = {pllRate_r[`NCP_XTAL_MSB:`NCP_XTAL_LSB], 3'h0,
                      pllRate_r[`NCP_PLL_RATE_MSB:`NCP_PLL_RATE_LSB]};
  assign rdPllPower = {forceVco_r, pllPowerDown_r, 6'h00};
  assign rdSel =
    (regAddr == `NCP_ADDR_FRONT_END) ? rdFrontEnd :
    (regAddr == `NCP_ADDR_PS_SEQ) ? psSeq_r :
    (regAddr == `NCP_ADDR_PS_RATE_DIV) ? psRateDiv_r :
    (regAddr == `NCP_ADDR_PLL_TUNE) ? pllTune_r :
    (regAddr == `NCP_ADDR_PLL_DIV) ? {1'b0, pllDiv_r[6:0]} :
    (regAddr == `NCP_ADDR_PLL_SEQ) ? pllSeq_r :
    (regAddr == `NCP_ADDR_PLL_RATE) ? rdPllRate :
    (regAddr == `NCP_ADDR_PLL_POWER) ? rdPllPower : 8'h00;

  // ============================================================
  // front end enable and pll power control
  logic powerWanted;
  logic pllDisable;
  assign powerWanted = frontEndEnable_r && !pllPowerDown_r;
  assign pllDisable = !powerWanted;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      frontEndEnable_r <= 1'b0;
    end else if (wrFrontEnd) begin
      frontEndEnable_r <= regWrData[`NCP_FE_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pllPowerDown_r <= 1'b0;
    end else if (wrPllPower) begin
      pllPowerDown_r <= regWrData[`NCP_PWDN_BIT];
    end
  end

  // force vco drops whenever the pll loses power, on the same edge for a 0Eh power-down write, one edge later for 00h
  always_ff @(posedge clk) begin
    if (!nrst) begin
      forceVco_r <= 1'b0;
    end else if (pllDisable) begin
      forceVco_r <= 1'b0;
    end else if (wrPllPower) begin
      forceVco_r <= regWrData[`NCP_FORCE_VCO_BIT] &&
                    !regWrData[`NCP_PWDN_BIT];
    end
  end

  always_comb begin
    pllState_nxt = pllState_r;
    unique case (pllState_r)
      ncp_pkg::NCP_PLL_OFF: begin
        if (powerWanted) begin
          pllState_nxt = ncp_pkg::NCP_PLL_ON;
        end
      end
      ncp_pkg::NCP_PLL_ON: begin
        if (!powerWanted) begin
          pllState_nxt = ncp_pkg::NCP_PLL_OFF;
        end
      end
      default: begin
        pllState_nxt = ncp_pkg::NCP_PLL_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pllState_r <= ncp_pkg::NCP_PLL_OFF;
    end else begin
      pllState_r <= pllState_nxt;
    end
  end

  // ============================================================
  // prescaler registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      psSeq_r <= `NCP_RST_PS_SEQ;
      psRateDiv_r <= `NCP_RST_PS_RATE_DIV;
    end else begin
      if (wrPsSeq) begin
        psSeq_r <= regWrData;
      end
      if (wrPsRateDiv) begin
        psRateDiv_r <= regWrData;
      end
    end
  end

  // ============================================================
  // pll tuning registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pllTune_r <= `NCP_RST_PLL_TUNE;
      pllDiv_r <= `NCP_RST_PLL_DIV;
      pllSeq_r <= `NCP_RST_PLL_SEQ;
      pllRate_r <= `NCP_RST_PLL_RATE;
    end else begin
      if (wrPllTune) begin
        pllTune_r <= regWrData;
      end
      if (wrPllDiv) begin
        pllDiv_r <= regWrData;
      end
      if (wrPllSeq) begin
        pllSeq_r <= regWrData;
      end
      if (wrPllRate) begin
        pllRate_r <= regWrData;
      end
    end
  end

  // commit on 0Dh
  // the divider keeps its old settings until 0Dh closes the update, so a
  // half-written set never reaches the loop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pllDivAct_r <= 7'(`NCP_RST_PLL_DIV);
      pllSeqAct_r <= `NCP_RST_PLL_SEQ;
      pllRateAct_r <= 3'(`NCP_RST_PLL_RATE);
    end else if (wrPllRate) begin
      pllDivAct_r <= pllDiv_r[`NCP_PLL_DIV_MSB:`NCP_PLL_DIV_LSB];
      pllSeqAct_r <= pllSeq_r;
      pllRateAct_r <= regWrData[`NCP_PLL_RATE_MSB:`NCP_PLL_RATE_LSB];
    end
  end

  // ============================================================
  // nco dividers
  logic psTick;
  logic fbTick;
  logic [6:0] pllDivUsed;
  // zero pll rate ignores divisor register
  // with a zero rate the divider runs at the reset divisor instead
  assign pllDivUsed = (pllRateAct_r == 3'h0) ?
                      7'(`NCP_RST_PLL_DIV) : pllDivAct_r;

  ncp_nco_div #(
    .W(5)
  ) u_prescaler (
    .clk(clk),
    .nrst(nrst),
    .tickIn(1'b1),
    .divisor(psRateDiv_r[`NCP_PS_DIV_MSB:`NCP_PS_DIV_LSB]),
    .seq(psSeq_r),
    .rate(psRateDiv_r[`NCP_PS_RATE_MSB:`NCP_PS_RATE_LSB]),
    .tickOut(psTick)
  );

  ncp_nco_div #(
    .W(7)
  ) u_pll_nco (
    .clk(clk),
    .nrst(nrst),
    .tickIn(vcoTick && pllState_r == ncp_pkg::NCP_PLL_ON),
    .divisor(pllDivUsed),
    .seq(pllSeqAct_r),
    .rate(pllRateAct_r),
    .tickOut(fbTick)
  );

  // ============================================================
  // output registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      regRdData <= 8'h00;
      pllRefTick <= 1'b0;
      pllFbTick <= 1'b0;
      pllPowerOn <= 1'b0;
      chargePumpCurrent <= 4'h0;
      loopFilterSelect <= 1'b0;
      vcoRange <= 3'h0;
      xtalBias <= 2'h0;
      forceVco <= 1'b0;
    end else begin
      if (regRdEn) begin
        regRdData <= rdSel;
      end
      pllRefTick <= psTick;
      pllFbTick <= fbTick;
      pllPowerOn <= pllState_r == ncp_pkg::NCP_PLL_ON;
      chargePumpCurrent <= pllTune_r[`NCP_CHP_MSB:`NCP_CHP_LSB];
      loopFilterSelect <= pllTune_r[`NCP_FILTER_BIT];
      vcoRange <= pllTune_r[`NCP_VCO_MSB:`NCP_VCO_LSB];
      xtalBias <= pllRate_r[`NCP_XTAL_MSB:`NCP_XTAL_LSB];
      forceVco <= forceVco_r;
    end
  end

endmodule : ncp_clock_config

`default_nettype wire

// ---- verification/ncp_vco_model.sv ----
// Purpose: behavioural vco standing behind the pll nco
// Assumes: one tick per crystal clock, or every other in slow mode
// Notes:   silent while the pll is powered off
`timescale 1ns/1ps
`default_nettype none
module ncp_vco_model (
  input wire logic clk,
  input wire logic powerOn,
  input wire logic slow,
  output logic vcoTick
);
  // no vco cycles while pll is off
  always_ff @(posedge clk) begin
    vcoTick <= powerOn && !(slow && vcoTick);
  end
endmodule : ncp_vco_model
`default_nettype wire

// ---- verification/ncp_clock_config_sva.sv ----
// Purpose: port checks of the clock configuration block
// Assumes: synchronous active-low reset
// Notes:   bound to every instance
`timescale 1ns/1ps
`default_nettype none
module ncp_clock_config_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic pllRefTick,
  input wire logic pllFbTick,
  input wire logic pllPowerOn,
  input wire logic [3:0] chargePumpCurrent,
  input wire logic loopFilterSelect,
  input wire logic [2:0] vcoRange,
  input wire logic forceVco
);
  logic [5:0] gapCnt_r;
  wire wrTune = regWrEn && regAddr == 7'h0a;
  wire wrOff0 = regWrEn && regAddr == 7'h00 && !regWrData[7];
  wire wrOffE = regWrEn && regAddr == 7'h0e && regWrData[6];
  wire [7:0] tune = {chargePumpCurrent, loopFilterSelect, vcoRange};
  // saturating count of cycles since the last reference tick
  always_ff @(posedge clk) begin
    if (!nrst || pllRefTick) gapCnt_r <= 6'h00;
    else if (gapCnt_r != 6'h3f) gapCnt_r <= gapCnt_r + 6'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_reset_defaults: assert property (disable iff (1'b0)
    !nrst |=> regRdData == 8'h00 && !pllPowerOn)
    else $error("outputs not cleared by reset");
  chk_tune_follows: assert property (wrTune |-> ##2
    tune == $past(regWrData, 2)) else $error("tuning outputs wrong");
  chk_tune_holds: assert property ($past(nrst) &&
    $past(nrst, 2) && !wrTune |-> ##2 $stable(tune))
    else $error("tuning outputs moved without write");
  chk_read_holds: assert property (!regRdEn |=>
    $stable(regRdData)) else $error("read data moved");
  chk_enable_off: assert property (wrOff0 |-> ##3
    !pllPowerOn && !forceVco) else $error("pll on without enable");
  chk_pwdn_off: assert property (wrOffE |-> ##3
    !pllPowerOn && !forceVco) else $error("pll on while powered down");
  chk_fb_silent: assert property (!pllPowerOn && !$past(pllPowerOn) &&
    !$past(pllPowerOn, 2) && !$past(pllPowerOn, 3) |-> !pllFbTick)
    else $error("feedback tick with pll off");
  chk_ref_running: assert property (gapCnt_r < 6'h28)
    else $error("reference ticks stopped");
endmodule : ncp_clock_config_sva
bind ncp_clock_config ncp_clock_config_sva u_sva (.clk, .nrst, .regWrEn,
  .regRdEn, .regAddr, .regWrData, .regRdData, .pllRefTick, .pllFbTick,
  .pllPowerOn, .chargePumpCurrent, .loopFilterSelect, .vcoRange,
  .forceVco);
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the clock configuration block
// Assumes: inputs driven at rising edges, one strobe per transfer
// Notes:   vco model ticks every cycle while the pll is on, unless slow is set
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWrData = 8'h00;
  logic slow = 1'b0;
  logic vcoTick;
  logic [7:0] regRdData;
  logic pllRefTick, pllFbTick, pllPowerOn, loopFilterSelect, forceVco;
  logic [3:0] chargePumpCurrent;
  logic [2:0] vcoRange;
  logic [1:0] xtalBias;
  int errors = 0;
  int tests_run = 0;
  int a, b, i;
  always #5 clk = ~clk;
  ncp_clock_config DUT (.clk, .nrst, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .vcoTick, .regRdData, .pllRefTick, .pllFbTick, .pllPowerOn,
    .chargePumpCurrent, .loopFilterSelect, .vcoRange, .xtalBias, .forceVco);
  ncp_vco_model VCO (.clk, .powerOn(pllPowerOn), .slow, .vcoTick);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: value %h not %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkn(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      errors++;
      $display("unexpected at %0t: count %0d not %0d", $time, got, exp);
    end
  endtask : chkn
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    regAddr <= ad;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [6:0] ad, input logic [7:0] exp);
    regAddr <= ad;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(negedge clk);
    chk(regRdData, exp);
    @(posedge clk);
  endtask : rd
  // outputs move up to two edges after the write edge
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle
  // cycles from the current tick to the next one
  task automatic gap(input logic fb, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((fb ? pllFbTick : pllRefTick) !== 1'b1 && n < 200);
    if (n >= 200) begin
      errors++;
      $display("unexpected at %0t: tick timeout", $time);
      give_verdict();
    end
    @(posedge clk);
  endtask : gap
  task automatic t_reset;
    rd(7'h08, 8'h00);
    rd(7'h09, 8'h0a);
    rd(7'h0a, 8'h22);
    rd(7'h20, 8'h00);
    chk({chargePumpCurrent, loopFilterSelect, vcoRange}, 8'h22);
    chk({6'h00, xtalBias}, 8'h03);
    chk({7'h00, pllPowerOn}, 8'h00);
    $display("reset defaults done");
  endtask : t_reset
  task automatic t_tune;
    logic [7:0] d;
    for (i = 0; i < 8; i++) begin
      d = 8'(i * 16 + (i % 2) * 8 + i);
      wr(7'h0a, d);
      settle();
      chk({chargePumpCurrent, loopFilterSelect, vcoRange}, d);
      @(posedge clk);
      rd(7'h0a, d);
    end
    $display("tuning codes done");
  endtask : t_tune
  task automatic t_presc;
    wr(7'h08, 8'hff);
    wr(7'h09, 8'h05);
    gap(1'b0, a);
    gap(1'b0, a);
    chkn(a, 5);
    wr(7'h08, 8'h01);
    wr(7'h09, 8'h24);
    gap(1'b0, a);
    gap(1'b0, a);
    gap(1'b0, b);
    chkn(a + b, 9);
    chkn(a * b, 20);
    $display("prescaler done");
  endtask : t_presc
  task automatic t_pll;
    wr(7'h00, 8'h80);
    settle();
    chk({7'h00, pllPowerOn}, 8'h01);
    @(posedge clk);
    gap(1'b1, a);
    gap(1'b1, a);
    chkn(a, 18);
    wr(7'h0b, 8'h03);
    wr(7'h0c, 8'h00);
    gap(1'b1, a);
    gap(1'b1, a);
    chkn(a, 18);
    wr(7'h0d, 8'hc1);
    gap(1'b1, a);
    gap(1'b1, a);
    chkn(a, 3);
    slow <= 1'b1;
    gap(1'b1, a);
    gap(1'b1, a);
    chkn(a, 6);
    slow <= 1'b0;
    wr(7'h0d, 8'hc0);
    gap(1'b1, a);
    gap(1'b1, a);
    chkn(a, 18);
    wr(7'h0e, 8'h80);
    settle();
    chk({7'h00, forceVco}, 8'h01);
    @(posedge clk);
    rd(7'h0e, 8'h80);
    wr(7'h0e, 8'h40);
    settle();
    chk({7'h00, pllPowerOn}, 8'h00);
    chk({7'h00, forceVco}, 8'h00);
    @(posedge clk);
    rd(7'h0e, 8'h40);
    wr(7'h0e, 8'h00);
    settle();
    chk({7'h00, pllPowerOn}, 8'h01);
    @(posedge clk);
    wr(7'h00, 8'h00);
    settle();
    chk({7'h00, pllPowerOn}, 8'h00);
    @(posedge clk);
    wr(7'h0d, 8'h40);
    settle();
    chk({6'h00, xtalBias}, 8'h01);
    @(posedge clk);
    rd(7'h0d, 8'h40);
    $display("pll nco and power done");
  endtask : t_pll
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tune();
    t_presc();
    t_pll();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
